/* File: logic/remote_command_channel_pkg.sv */
/*
  Constants, field positions and carrier types for the remote command channel.
  Assumes a single clock domain and a host that writes the channel register
  from logic on the same clock.
*/
// Function
// - Clear register on reset, then post ready pattern
// - Bit 0 set means host holds register
// - Bits 1-7 carry the command opcode
// - Bit 8 reports failure on completion
// - Option bit 9 clear enables console reporting
// - Bits 16-31 carry input data or result
// - Opcode 1 reads or writes a virtual half
// - Virtual register access never reports failure
// - Opcode 2 fills memory with data byte
// - Opcode 3 address zero, data via register one
// - Option 14 auto-increments address by access size
// - Option bits 12-13 encode the access size
// - Memory access ignores bit 9, no reporting
// - Illegal size fails with code one
// - Unsupported opcode fails with code two
// - Opcode 4 returns sixteen-bit checksum, registers kept
// - Opcode 5 puts a memory boundary in register one
// - Opcode 6 returns major and minor revision
// - Opcode 7 jumps, completion never signalled
// - Device sets holds flag after writing results
// - Bit numbering counts from the most significant end
package remote_command_channel_pkg;

  // ************************************************************
  // Channel register layout (bit 31 is the most significant bit).
  // ************************************************************
  localparam int unsigned HOLD_POS = 31;
  localparam int unsigned OPC_LSB = 24;
  localparam int unsigned FAIL_POS = 23;
  localparam int unsigned OPT_LSB = 16;
  localparam int unsigned DATA_LSB = 0;
  localparam int unsigned OPT_QUIET = 6;
  localparam int unsigned OPT_WRITE = 0;
  localparam int unsigned OPT_HALF = 1;
  localparam int unsigned OPT_SEL_LSB = 3;
  localparam int unsigned OPT_SIZE_LSB = 2;
  localparam logic [31:0] READY_PATTERN = 32'h8052_5354;
  localparam logic [31:0] CHAN_RESET = 32'h0000_0000;

  // ************************************************************
  // Opcodes, sizes and failure codes.
  // ************************************************************
  localparam logic [6:0] OPC_VREG = 7'h01;
  localparam logic [6:0] OPC_FILL = 7'h02;
  localparam logic [6:0] OPC_MEM = 7'h03;
  localparam logic [6:0] OPC_SUM = 7'h04;
  localparam logic [6:0] OPC_SIZE = 7'h05;
  localparam logic [6:0] OPC_REV = 7'h06;
  localparam logic [6:0] OPC_EXEC = 7'h07;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [15:0] ERR_SIZE = 16'h0001;
  localparam logic [15:0] ERR_OPCODE = 16'h0002;
  localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
  localparam logic [31:0] CRC_POLY = 32'h04c1_1db6;

  // ************************************************************
  // Carrier types.
  // ************************************************************
  typedef struct packed {
    logic hold;
    logic [6:0] opcode;
    logic fail;
    logic [6:0] options;
    logic [15:0] data;
  } chan_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic jump;
    logic [31:0] jump_addr;
    logic [31:0] cpu_argument_register;
  } exec_t;

endpackage : remote_command_channel_pkg

/* File: logic/checksum_byte_step.sv */
/*
  Combinational checksum step: folds one byte into the running checksum
  and offers the finished sixteen-bit result of the current value.
  Assumes the caller holds the running value in its own register.
*/
`timescale 1ns/10ps
module checksum_byte_step
  import remote_command_channel_pkg::*;
(
  input wire logic [31:0] crc_in,
  input wire logic [7:0] byte_in,
  output logic [31:0] crc_out,
  output logic [15:0] sum_out
);

  // ************************************************************
  // Serial update, least significant data bit first.
  // ************************************************************
  always_comb begin
    logic [31:0] c;
    logic [31:0] flip;
    logic msb;
    c = crc_in;
    flip = '0;
    msb = 1'b0;
    for (int i = 0; i < 8; i++) begin
      msb = c[31];
      c = {c[30:0], 1'b0};
      if (msb ^ byte_in[i]) begin
        c = (c ^ CRC_POLY) | 32'h0000_0001;
      end
    end
    crc_out = c;
    for (int j = 0; j < 32; j++) begin
      flip[j] = crc_in[31 - j];
    end
    sum_out = ~flip[15:0];
  end

endmodule : checksum_byte_step

/* File: logic/remote_command_channel.sv */
/*
  Command interpreter behind the host channel register: decodes host
  commands, keeps four virtual registers, drives a local memory master
  and a jump request toward the local processor.
  Assumes the host writer and the local memory bus share clk_in, and that
  the memory bus answers each request with a one-cycle acknowledge.
*/
`timescale 1ns/10ps
module remote_command_channel
  import remote_command_channel_pkg::*;
#(
  parameter logic [31:0] RAM_START = 32'h0000_0000,
  parameter logic [31:0] RAM_END = 32'h0200_0000,
  parameter logic [31:0] FREE_START = 32'h0010_0000,
  parameter logic [31:0] FREE_END = 32'h01f0_0000,
  // Revision values are arbitrary.
  parameter logic [7:0] REV_MAJOR = 8'h01,
  parameter logic [7:0] REV_MINOR = 8'h00
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic host_wr_in,
  input wire logic [31:0] host_wdata_in,
  output logic [31:0] chan_out,
  output mem_req_t mem_out,
  input wire logic mem_ack_in,
  input wire logic [31:0] mem_rdata_in,
  output exec_t exec_out,
  output logic report_out,
  output logic [6:0] report_opcode_out
);

  // ************************************************************
  // State and helpers.
  // ************************************************************
  typedef enum logic [2:0] {
    ST_INIT,
    ST_IDLE,
    ST_RUN,
    ST_MEM,
    ST_FILL,
    ST_SUM,
    ST_DONE
  } state_t;

  typedef struct packed {
    state_t state;
    chan_t chan;
    logic [3:0][31:0] vreg;
    logic [31:0] count;
    logic [31:0] crc;
    mem_req_t mem;
    exec_t exec;
    logic report;
    logic [6:0] report_opcode;
  } regs_t;

  regs_t st_r;
  regs_t st_nxt;
  logic [31:0] crc_step;
  logic [15:0] crc_sum;

  function automatic logic [31:0] size_bytes(input logic [1:0] sz);
    case (sz)
      SIZE_BYTE: size_bytes = 32'h0000_0001;
      SIZE_HALF: size_bytes = 32'h0000_0002;
      SIZE_WORD: size_bytes = 32'h0000_0004;
      default: size_bytes = 32'h0000_0000;
    endcase
  endfunction : size_bytes

  function automatic logic [31:0] size_mask(input logic [1:0] sz);
    case (sz)
      SIZE_BYTE: size_mask = 32'h0000_00ff;
      SIZE_HALF: size_mask = 32'h0000_ffff;
      default: size_mask = 32'hffff_ffff;
    endcase
  endfunction : size_mask

  checksum_byte_step u_sum (
    .crc_in(st_r.crc),
    .byte_in(mem_rdata_in[7:0]),
    .crc_out(crc_step),
    .sum_out(crc_sum)
  );

  // ************************************************************
  // Next state.
  // ************************************************************
  always_comb begin
    logic [1:0] sel;
    logic [1:0] sz;
    logic [6:0] opt;
    logic [31:0] msk;
    st_nxt = st_r;
    st_nxt.report = 1'b0;
    st_nxt.exec.jump = 1'b0;
    opt = st_r.chan.options;
    sel = {opt[OPT_SEL_LSB + 1], opt[OPT_SEL_LSB]};
    sz = {opt[OPT_SIZE_LSB + 1], opt[OPT_SIZE_LSB]};
    msk = size_mask(st_r.mem.size);
    case (st_r.state)
      ST_INIT: begin
        st_nxt.chan = chan_t'(READY_PATTERN);
        st_nxt.state = ST_IDLE;
      end
      ST_IDLE: begin
        if (host_wr_in) begin
          st_nxt.chan = chan_t'(host_wdata_in);
          if (!host_wdata_in[HOLD_POS]) begin
            st_nxt.state = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        st_nxt.chan.fail = 1'b0;
        st_nxt.state = ST_DONE;
        st_nxt.report_opcode = st_r.chan.opcode;
        st_nxt.report = !opt[OPT_QUIET] && (st_r.chan.opcode != OPC_MEM);
        case (st_r.chan.opcode)
          OPC_VREG: begin
            if (opt[OPT_WRITE]) begin
              if (opt[OPT_HALF]) begin
                st_nxt.vreg[sel][31:16] = st_r.chan.data;
              end else begin
                st_nxt.vreg[sel][15:0] = st_r.chan.data;
              end
            end else begin
              st_nxt.chan.data = opt[OPT_HALF] ? st_r.vreg[sel][31:16] : st_r.vreg[sel][15:0];
            end
          end
          OPC_FILL: begin
            st_nxt.count = 32'h0000_0000;
            st_nxt.state = ST_FILL;
          end
          OPC_MEM: begin
            if (sz == 2'h3) begin
              st_nxt.chan.fail = 1'b1;
              st_nxt.chan.data = ERR_SIZE;
            end else begin
              st_nxt.mem.req = 1'b1;
              st_nxt.mem.we = opt[OPT_WRITE];
              st_nxt.mem.size = sz;
              st_nxt.mem.addr = st_r.vreg[0];
              st_nxt.mem.wdata = {st_r.vreg[1][31:16], st_r.chan.data} & size_mask(sz);
              st_nxt.state = ST_MEM;
            end
          end
          OPC_SUM: begin
            st_nxt.count = 32'h0000_0000;
            st_nxt.crc = CRC_INIT;
            st_nxt.state = ST_SUM;
          end
          OPC_SIZE: begin
            case ({opt[OPT_WRITE], opt[OPT_HALF]})
              2'h0: st_nxt.vreg[1] = RAM_START;
              2'h1: st_nxt.vreg[1] = RAM_END;
              2'h2: st_nxt.vreg[1] = FREE_START;
              default: st_nxt.vreg[1] = FREE_END;
            endcase
          end
          OPC_REV: begin
            st_nxt.chan.data = {REV_MAJOR, REV_MINOR};
          end
          OPC_EXEC: begin
            st_nxt.exec.jump = 1'b1;
            st_nxt.exec.jump_addr = st_r.vreg[0];
            st_nxt.exec.cpu_argument_register = st_r.vreg[2];
            st_nxt.state = ST_IDLE;
          end
          default: begin
            st_nxt.chan.fail = 1'b1;
            st_nxt.chan.data = ERR_OPCODE;
          end
        endcase
      end
      ST_MEM: begin
        if (mem_ack_in) begin
          st_nxt.mem.req = 1'b0;
          if (!st_r.mem.we) begin
            st_nxt.vreg[1] = mem_rdata_in & msk;
            st_nxt.chan.data = mem_rdata_in[15:0] & msk[15:0];
          end
          if (opt[OPT_HALF]) begin
            st_nxt.vreg[0] = st_r.vreg[0] + size_bytes(st_r.mem.size);
          end
          st_nxt.state = ST_DONE;
        end
      end
      ST_FILL: begin
        // Fill walks upward one byte per acknowledge; no alignment is promised.
        if (st_r.mem.req) begin
          if (mem_ack_in) begin
            st_nxt.mem.req = 1'b0;
            st_nxt.count = st_r.count + 32'h0000_0001;
          end
        end else if (st_r.count == st_r.vreg[1]) begin
          st_nxt.state = ST_DONE;
        end else begin
          st_nxt.mem.req = 1'b1;
          st_nxt.mem.we = 1'b1;
          st_nxt.mem.size = SIZE_BYTE;
          st_nxt.mem.addr = st_r.vreg[0] + st_r.count;
          st_nxt.mem.wdata = {24'h000000, st_r.chan.data[7:0]};
        end
      end
      ST_SUM: begin
        if (st_r.mem.req) begin
          if (mem_ack_in) begin
            st_nxt.mem.req = 1'b0;
            st_nxt.crc = crc_step;
            st_nxt.count = st_r.count + 32'h0000_0001;
          end
        end else if (st_r.count == st_r.vreg[1]) begin
          st_nxt.chan.data = crc_sum;
          st_nxt.state = ST_DONE;
        end else begin
          st_nxt.mem.req = 1'b1;
          st_nxt.mem.we = 1'b0;
          st_nxt.mem.size = SIZE_BYTE;
          st_nxt.mem.addr = st_r.vreg[0] + st_r.count;
          st_nxt.mem.wdata = 32'h0000_0000;
        end
      end
      ST_DONE: begin
        st_nxt.chan.hold = 1'b1;
        st_nxt.state = ST_IDLE;
      end
      default: begin
        st_nxt.state = ST_IDLE;
      end
    endcase
  end

  // ************************************************************
  // Registers.
  // ************************************************************
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r.state <= ST_INIT;
      st_r.chan <= chan_t'(CHAN_RESET);
      st_r.vreg <= '0;
      st_r.count <= '0;
      st_r.crc <= '0;
      st_r.mem <= '0;
      st_r.exec <= '0;
      st_r.report <= 1'b0;
      st_r.report_opcode <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign chan_out = st_r.chan;
  assign mem_out = st_r.mem;
  assign exec_out = st_r.exec;
  assign report_out = st_r.report;
  assign report_opcode_out = st_r.report_opcode;

endmodule : remote_command_channel

/* File: test/remote_command_channel_assertions.sv */
/* Port checker for the remote command channel.
   Assumes it is bound into the design top module. */
`timescale 1ns/10ps
module remote_command_channel_assertions
  import remote_command_channel_pkg::*;
#(
  parameter logic [7:0] REV_MAJOR = 8'h01,
  parameter logic [7:0] REV_MINOR = 8'h00
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic host_wr_in,
  input wire logic [31:0] chan_out,
  input mem_req_t mem_out,
  input wire logic mem_ack_in,
  input exec_t exec_out,
  input wire logic report_out,
  input wire logic [6:0] report_opcode_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  logic hold_r, wr_r, done;
  logic [6:0] opc;
  assign opc = chan_out[30:24];
  // A host write with the flag set also raises it, so it is not a completion.
  assign done = chan_out[31] && !hold_r && !wr_r && chan_out != READY_PATTERN;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hold_r <= 1'h1;
      wr_r <= 1'h0;
    end else begin
      hold_r <= chan_out[31];
      wr_r <= host_wr_in;
    end
  end
  ready_after_reset_a: assert property ($rose(arst_n_in) |-> ##1 chan_out == READY_PATTERN)
    else $error("ready pattern missing");
  opcode_error_a: assert property (done && (opc == 7'h00 || opc > OPC_EXEC) |->
    chan_out[23] && chan_out[15:0] == ERR_OPCODE) else $error("unsupported opcode result");
  size_error_a: assert property (done && opc == OPC_MEM && chan_out[19:18] == 2'h3 |->
    chan_out[23] && chan_out[15:0] == ERR_SIZE) else $error("illegal size result");
  vreg_no_fail_a: assert property (done && opc == OPC_VREG |-> !chan_out[23])
    else $error("register access failed");
  revision_result_a: assert property (done && opc == OPC_REV |->
    !chan_out[23] && chan_out[15:0] == {REV_MAJOR, REV_MINOR}) else $error("revision result");
  exec_no_done_a: assert property (exec_out.jump |-> !chan_out[31] [*3])
    else $error("jump signalled completion");
  mem_req_held_a: assert property (mem_out.req && !mem_ack_in |=> mem_out.req && $stable(mem_out))
    else $error("request dropped early");
  mem_no_report_a: assert property (report_out |-> report_opcode_out != OPC_MEM && !chan_out[22])
    else $error("report not allowed");
  cover property (done && opc == OPC_MEM);
  cover property (done && chan_out[23]);
  cover property (exec_out.jump);
endmodule : remote_command_channel_assertions
bind remote_command_channel remote_command_channel_assertions #(.REV_MAJOR(REV_MAJOR), .REV_MINOR(REV_MINOR))
  i_chk (.clk_in(clk_in), .arst_n_in(arst_n_in), .host_wr_in(host_wr_in), .chan_out(chan_out),
  .mem_out(mem_out), .mem_ack_in(mem_ack_in), .exec_out(exec_out), .report_out(report_out),
  .report_opcode_out(report_opcode_out));

/* File: test/local_memory_model.sv */
/* Byte memory answering the channel's local memory requests.
   Assumes one request at a time, held until acknowledged. */
`timescale 1ns/10ps
module local_memory_model
  import remote_command_channel_pkg::*;
(
  input wire logic clk_in,
  input mem_req_t mem_in,
  input wire logic [1:0] lat_in,
  output logic ack_out = 1'h0,
  output logic [31:0] rdata_out = 32'h0
);
  logic [7:0] m [1024] = '{default: 8'h0};
  logic [9:0] a;
  int w = 0;
  assign a = mem_in.addr[9:0];
  // An idle bus shows the inverse, so a stale value never passes.
  always @(posedge clk_in) begin
    ack_out <= 1'h0;
    rdata_out <= ~rdata_out;
    if (mem_in.req && !ack_out && w < lat_in) begin
      w++;
    end else if (mem_in.req && !ack_out) begin
      w = 0;
      ack_out <= 1'h1;
      rdata_out <= {m[a + 3], m[a + 2], m[a + 1], m[a]};
      for (int i = 0; i < 4; i++) begin
        if (mem_in.we && i < (1 << mem_in.size)) m[a + i] = mem_in.wdata[8 * i +: 8];
      end
    end
  end
endmodule : local_memory_model

/* File: test/test_remote_command_channel.sv */
/* Self-checking bench for the remote command channel.
   Assumes the checker is bound and the memory model sits on the bus. */
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %0t got %h exp %h", $time, g, e); end end
module test_remote_command_channel
  import remote_command_channel_pkg::*;
;
  localparam logic [31:0] BND [4] = '{32'h0, 32'h8_0000, 32'h4000, 32'h7_c000};
  logic clk_in = 1'h0, arst_n_in = 1'h0, host_wr_in = 1'h0, mem_ack_in;
  logic [31:0] host_wdata_in = 32'h0, chan_out, mem_rdata_in, v, m;
  logic [31:0] vr [4] = '{default: 32'h0};
  logic [7:0] bm [1024] = '{default: 8'h0};
  logic [6:0] bad [3] = '{7'h0, 7'h8, 7'h7f};
  logic [1:0] lat = 2'h0;
  logic [15:0] d;
  logic report_out;
  logic [6:0] report_opcode_out;
  logic [7:0] reports = 8'h0;
  mem_req_t mem_out;
  exec_t exec_out;
  int fails = 0, checks_done = 0, n;
  integer seed = 32'h2acc;
  always #4 clk_in = ~clk_in;
  always @(posedge clk_in) reports <= reports + 8'(report_out);
  remote_command_channel #(.RAM_START(BND[0]), .RAM_END(BND[1]), .FREE_START(BND[2]), .FREE_END(BND[3]),
    .REV_MAJOR(8'h03), .REV_MINOR(8'h07)) i_dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .host_wr_in(host_wr_in), .host_wdata_in(host_wdata_in), .chan_out(chan_out), .mem_out(mem_out),
    .mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in), .exec_out(exec_out), .report_out(report_out),
    .report_opcode_out(report_opcode_out));
  local_memory_model i_mem (.clk_in(clk_in), .mem_in(mem_out), .lat_in(lat), .ack_out(mem_ack_in),
    .rdata_out(mem_rdata_in));
  task automatic issue(input logic [31:0] word);
    host_wdata_in = word;
    host_wr_in = 1'h1;
    @(posedge clk_in) #1;
    host_wr_in = 1'h0;
  endtask : issue
  task automatic run(input logic [6:0] opc, opt, input logic [15:0] dat, input logic ef,
    input logic [15:0] ed, input logic cd);
    logic [7:0] r0;
    r0 = reports;
    issue({1'h0, opc, 1'h0, opt, dat});
    for (n = 0; chan_out[31] !== 1'h1 && n < 300; n++) @(posedge clk_in) #1;
    `CHK({chan_out[31], chan_out[23]}, {1'h1, ef})
    if (cd) `CHK(chan_out[15:0], ed)
    `CHK(8'(reports - r0), {7'h0, !opt[OPT_QUIET] && opc != OPC_MEM})
    if (!opt[OPT_QUIET] && opc != OPC_MEM) `CHK(report_opcode_out, opc)
  endtask : run
  task automatic vreg(input int s, input logic h, w, input logic [15:0] dat);
    d = h ? vr[s][31:16] : vr[s][15:0];
    if (w) vr[s] = h ? {dat, vr[s][15:0]} : {vr[s][31:16], dat};
    v = $random(seed);
    run(OPC_VREG, {v[0], 1'h0, s[1:0], 1'h0, h, w}, dat, 1'h0, d, !w);
  endtask : vreg
  task automatic setvr(input int s, input logic [31:0] x);
    vreg(s, 1'h1, 1'h1, x[31:16]);
    vreg(s, 1'h0, 1'h1, x[15:0]);
  endtask : setvr
  task automatic getvr(input int s);
    vreg(s, 1'h1, 1'h0, 16'h0);
    vreg(s, 1'h0, 1'h0, 16'h0);
  endtask : getvr
  task automatic mem(input logic [1:0] sz, input logic w, input logic [15:0] dat);
    logic [9:0] a;
    logic inc;
    a = vr[0][9:0];
    inc = w || sz != 2'h1;
    m = ~(32'hffff_ffff << (8 << sz));
    v = m & (w ? {vr[1][31:16], dat} : {bm[a + 3], bm[a + 2], bm[a + 1], bm[a]});
    for (int i = 0; i < 4; i++) begin
      if (w && m[8 * i]) bm[a + i] = v[8 * i +: 8];
    end
    if (!w) vr[1] = v;
    if (inc) vr[0] = vr[0] + (32'h1 << sz);
    lat = 2'($random(seed));
    run(OPC_MEM, {3'h0, sz, inc, w}, dat, 1'h0, v[15:0], !w);
  endtask : mem
  function automatic logic [15:0] crc16(input int a, k);
    logic [31:0] c, f;
    logic [7:0] b;
    c = CRC_INIT;
    for (int i = 0; i < k; i++) begin
      b = bm[a + i];
      for (int j = 0; j < 8; j++) begin
        c = (c[31] ^ b[0]) ? ((c << 1) ^ CRC_POLY) | 32'h1 : c << 1;
        b = b >> 1;
      end
    end
    f = {<<{c}};
    return ~f[15:0];
  endfunction : crc16
  task automatic results();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  initial begin
    repeat (10) @(posedge clk_in);
    #1 arst_n_in = 1'h1;
    @(posedge clk_in) #1;
    `CHK(chan_out, READY_PATTERN)
    for (int k = 0; k < 8; k++) begin
      vreg(k / 2, k[0], 1'h0, 16'h0);
      vreg(k / 2, k[0], 1'h1, 16'($random(seed)));
      vreg(k / 2, k[0], 1'h0, 16'h0);
    end
    for (int k = 0; k < 6; k++) begin
      if (k % 3 == 0) setvr(0, 32'h100);
      mem(2'(k % 3), k < 3, 16'($random(seed)));
    end
    run(OPC_MEM, 7'h0c, 16'h0, 1'h1, ERR_SIZE, 1'h1);
    getvr(0);
    getvr(1);
    setvr(0, 32'h200);
    setvr(1, 32'h7);
    d = 16'($random(seed));
    run(OPC_FILL, 7'h0, d, 1'h0, d, 1'h0);
    for (int i = 0; i < 7; i++) bm[32'h200 + i] = d[7:0];
    run(OPC_SUM, 7'h0, 16'h0, 1'h0, crc16(32'h200, 7), 1'h1);
    getvr(0);
    getvr(1);
    for (int k = 0; k < 4; k++) begin
      run(OPC_SIZE, {5'h0, k[0], k[1]}, 16'h5a5a, 1'h0, 16'h5a5a, 1'h1);
      vr[1] = BND[k];
      getvr(1);
    end
    run(OPC_REV, 7'h0, 16'h0, 1'h0, 16'h0307, 1'h1);
    foreach (bad[i]) run(bad[i], 7'h0, 16'h1234, 1'h1, ERR_OPCODE, 1'h1);
    issue({1'h1, OPC_REV, 24'h0});
    repeat (3) @(posedge clk_in) #1;
    `CHK(chan_out, {1'h1, OPC_REV, 24'h0})
    setvr(0, 32'h4_0200);
    setvr(2, 32'h4_0100);
    issue({1'h0, OPC_EXEC, 24'h0});
    for (n = 0; exec_out.jump !== 1'h1 && n < 20; n++) @(posedge clk_in) #1;
    `CHK({exec_out.jump, exec_out.jump_addr, exec_out.cpu_argument_register}, {1'h1, vr[0], vr[2]})
    repeat (4) @(posedge clk_in) #1;
    `CHK(chan_out[31], 1'h0)
    results();
  end
  // Far beyond the few hundred cycles the sequence needs.
  initial begin
    #400000;
    fails++;
    results();
  end
endmodule : test_remote_command_channel
